// ### sem_ecc_mem.sv
/*
 * Soft-ECC two-port memory: writes on port A are encoded, reads on port B
 * are decoded with single-bit correction and single/double fault flags.
 * Assumes user logic on the same clock drives both ports.
 */
//Contract
// - Injected write stores corrupted word, flagged later
// - Both injections together: double-bit fault wins
// - Double-injected word flags double only
// - Double fault read returns uncorrected data
// - Narrow read against wide write, and mirror
// - Unequal widths avoid simple two-port layout
`timescale 1ns/1ps
module sem_ecc_mem #(
    parameter int WR_WIDTH = sem_pkg::WR_WIDTH_DEF,
    parameter int RD_WIDTH = sem_pkg::RD_WIDTH_DEF,
    parameter int WR_DEPTH = sem_pkg::WR_DEPTH_DEF,
    localparam int G = (WR_WIDTH < RD_WIDTH) ? WR_WIDTH : RD_WIDTH,
    localparam int WR_UNITS = WR_WIDTH / G,
    localparam int RD_UNITS = RD_WIDTH / G,
    localparam int UNITS = WR_DEPTH * WR_UNITS,
    localparam int RD_DEPTH = UNITS / RD_UNITS,
    localparam int WAW = $clog2(WR_DEPTH),
    localparam int RAW = $clog2(RD_DEPTH)
) (
    input wire logic MCLK_I,                      // System clock
    input wire logic RST_B_I,                     // Async reset, low
    input wire logic WR_EN_I,                     // Port A write
    input wire logic [WAW-1:0] WR_ADDR_I,         // Port A address
    input wire logic [WR_WIDTH-1:0] WR_DATA_I,    // Port A data
    input wire logic INJ_SBIT_I,                  // Inject one-bit fault
    input wire logic INJ_DBIT_I,                  // Inject two-bit fault
    input wire logic RD_EN_I,                     // Port B read
    input wire logic [RAW-1:0] RD_ADDR_I,         // Port B address
    output logic [RD_WIDTH-1:0] RD_DATA_O,        // Port B data
    output logic RD_VALID_O,                      // Read answer strobe
    output logic SBIT_ERR_O,                      // Corrected one-bit fault
    output logic DBIT_ERR_O,                      // Uncorrected two-bit fault
    output logic [RAW-1:0] RD_ADDR_ECC_O,         // Address of answer
    output logic SIMPLE_TWO_PORT_LAYOUT_O         // Equal-width organisation
);
    localparam int CW = G + sem_pkg::sem_check_bits(G) + 1;
    localparam int UAW = (UNITS > 1) ? $clog2(UNITS) : 1;
    localparam int LANES = (WR_UNITS > RD_UNITS) ? WR_UNITS : RD_UNITS;
    localparam bit SIMPLE_LAYOUT = (WR_WIDTH == RD_WIDTH);

    // Refuse geometries the lane storage cannot serve
    if (WR_WIDTH < 1 || RD_WIDTH < 1 || WR_WIDTH > sem_pkg::MAX_DATA
        || RD_WIDTH > sem_pkg::MAX_DATA || (LANES * G) != (WR_WIDTH > RD_WIDTH ?
        WR_WIDTH : RD_WIDTH) || WR_DEPTH < 2 || (1 << WAW) != WR_DEPTH
        || RD_DEPTH < 2) begin : g_bad_cfg
        $error("sem_ecc_mem: unsupported width or depth combination");
    end

    // Storage index of lane j of an access at address a of n lanes
    function automatic logic [UAW-1:0] unit_of(input int a, input int n, input int j);
        return UAW'(a * n + j);
    endfunction

    logic [CW-1:0] mem [UNITS];             // Codeword storage, one per lane unit
    logic [CW-1:0] enc_word [LANES];        // Encoded write words
    logic [CW-1:0] rd_word [LANES];         // Stored words being read
    logic [G-1:0] dec_data [LANES];         // Decoded lane data
    logic dec_s [LANES];                    // Lane single fault
    logic dec_d [LANES];                    // Lane double fault
    logic [CW-1:0] inj_mask;                // Fault pattern for lane 0
    logic [UAW-1:0] last_wr_unit;           // Lane 0 unit of the last write

    for (genvar j = 0; j < LANES; j++) begin : g_lane
        sem_lane_if #(.K(G)) lane ();
        sem_lane_codec #(.K(G)) u_codec (.lane(lane));
        assign lane.wr_data = (j < WR_UNITS) ? WR_DATA_I[(j % WR_UNITS)*G +: G] : '0;
        assign lane.rd_word = (j < RD_UNITS) ? mem[unit_of(int'(RD_ADDR_I), RD_UNITS, j)] : '0;
        assign rd_word[j] = lane.rd_word;
        assign enc_word[j] = lane.wr_word;
        assign dec_data[j] = lane.rd_data;
        assign dec_s[j] = lane.rd_sbit;
        assign dec_d[j] = lane.rd_dbit;
    end

    // Fault pattern for an injected write
    always_comb begin
        inj_mask = '0;
        if (INJ_DBIT_I) begin
            inj_mask[sem_pkg::INJ_DBIT_POS_A] = 1'b1;
            inj_mask[sem_pkg::INJ_DBIT_POS_B] = 1'b1;
        end else if (INJ_SBIT_I) begin
            inj_mask[sem_pkg::INJ_SBIT_POS] = 1'b1;
        end
    end

    // Memory write; lane 0 takes the injected fault
    always_ff @(posedge MCLK_I) begin
        if (WR_EN_I) begin
            for (int j = 0; j < WR_UNITS; j++) begin
                mem[unit_of(int'(WR_ADDR_I), WR_UNITS, j)] <=
                    (j == 0) ? (enc_word[j] ^ inj_mask) : enc_word[j];
            end
        end
    end

    logic [RD_WIDTH-1:0] next_rd_data;   // Next read data
    logic next_rd_valid;                 // Next answer strobe
    logic next_sbit;                     // Next single flag
    logic next_dbit;                     // Next double flag
    logic [RAW-1:0] next_rd_addr;        // Next answer address
    logic [UAW-1:0] next_last_wr_unit;   // Next last write unit
    logic any_s;                         // Some lane single fault
    logic any_d;                         // Some lane double fault

    // Read answer computation
    always_comb begin
        any_s = 1'b0;
        any_d = 1'b0;
        next_rd_data = RD_DATA_O;
        for (int j = 0; j < RD_UNITS; j++) begin
            any_s = any_s | dec_s[j];
            any_d = any_d | dec_d[j];
            if (RD_EN_I) begin
                next_rd_data[j*G +: G] = dec_data[j];
            end
        end
        next_rd_valid = RD_EN_I;
        next_sbit = RD_EN_I & any_s & ~any_d;
        next_dbit = RD_EN_I & any_d;
        next_rd_addr = RD_EN_I ? RD_ADDR_I : RD_ADDR_ECC_O;
        next_last_wr_unit = WR_EN_I ? unit_of(int'(WR_ADDR_I), WR_UNITS, 0) : last_wr_unit;
    end

    // Output and tracking registers
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            RD_DATA_O <= '0;
            RD_VALID_O <= 1'b0;
            SBIT_ERR_O <= 1'b0;
            DBIT_ERR_O <= 1'b0;
            RD_ADDR_ECC_O <= '0;
            SIMPLE_TWO_PORT_LAYOUT_O <= 1'b0;
            last_wr_unit <= '0;
        end else begin
            RD_DATA_O <= next_rd_data;
            RD_VALID_O <= next_rd_valid;
            SBIT_ERR_O <= next_sbit;
            DBIT_ERR_O <= next_dbit;
            RD_ADDR_ECC_O <= next_rd_addr;
            SIMPLE_TWO_PORT_LAYOUT_O <= SIMPLE_LAYOUT;
            last_wr_unit <= next_last_wr_unit;
        end
    end

    sem_pkg::sem_dec_s probe;   // Decode of the last written lane-0 unit, checks only

    // Re-decodes the stored lane-0 word of the last write for the storage checks
    always_comb begin
        probe = sem_pkg::sem_decode(sem_pkg::sem_cw_t'(mem[last_wr_unit]), G);
    end

    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_B_I);

    // Injected writes leave exactly the intended fault in storage
    chk_single_inject: assert property (
        $past(WR_EN_I && INJ_SBIT_I && !INJ_DBIT_I) |-> probe.sbit)
        else $error("single injection did not store a one-bit fault");
    chk_double_wins: assert property (
        $past(WR_EN_I && INJ_SBIT_I && INJ_DBIT_I) |-> probe.dbit && !probe.sbit)
        else $error("double injection did not win");
    chk_double_only: assert property (
        RD_EN_I && any_d |=> DBIT_ERR_O && !SBIT_ERR_O)
        else $error("double fault read raised the single flag");
    chk_raw_on_double: assert property (
        RD_EN_I && dec_d[0] |=>
            RD_DATA_O[G-1:0] == $past(sem_pkg::sem_extract(sem_pkg::sem_cw_t'(rd_word[0]), G)))
        else $error("double fault data was altered");
    chk_read_answer: assert property (
        RD_EN_I |=> RD_VALID_O && RD_ADDR_ECC_O == $past(RD_ADDR_I)
            ##1 (RD_VALID_O == $past(RD_EN_I)))
        else $error("read answer strobe or address wrong");
    chk_layout_flag: assert property (
        $past(RST_B_I) |-> SIMPLE_TWO_PORT_LAYOUT_O == SIMPLE_LAYOUT)
        else $error("layout flag wrong");
    chk_single_fixed: assert property (
        RD_EN_I && dec_s[0] && !any_d |=> SBIT_ERR_O &&
            $countones(sem_pkg::sem_encode(sem_pkg::sem_data_t'(RD_DATA_O[G-1:0]), G)
            ^ sem_pkg::sem_cw_t'($past(rd_word[0]))) == 1)
        else $error("single fault not corrected");
    chk_clean_quiet: assert property (
        RD_EN_I && !any_s && !any_d |=> !SBIT_ERR_O && !DBIT_ERR_O)
        else $error("clean read raised a flag");
    // Flags only ride on an answer, and never both at once
    chk_flags_exclusive: assert property (
        !(SBIT_ERR_O && DBIT_ERR_O))
        else $error("both fault flags raised together");
    chk_flags_on_answer: assert property (
        (SBIT_ERR_O || DBIT_ERR_O) |-> RD_VALID_O)
        else $error("fault flag raised without an answer");
    // An idle read port gives no answer in the next cycle
    chk_idle_quiet: assert property (
        !RD_EN_I |=> !RD_VALID_O && !SBIT_ERR_O && !DBIT_ERR_O)
        else $error("answer strobe without a read");
    // A write without injection stores a word that decodes clean
    chk_clean_write: assert property (
        $past(WR_EN_I && !INJ_SBIT_I && !INJ_DBIT_I) |-> !probe.sbit && !probe.dbit)
        else $error("clean write stored a faulty word");

    // Main scenarios: clean, corrected and uncorrected reads, both injections
    cov_clean_read: cover property (RD_EN_I ##1 RD_VALID_O && !SBIT_ERR_O && !DBIT_ERR_O);
    cov_single_read: cover property (RD_EN_I ##1 SBIT_ERR_O);
    cov_double_read: cover property (RD_EN_I ##1 DBIT_ERR_O);
    cov_both_inject: cover property (WR_EN_I && INJ_SBIT_I && INJ_DBIT_I);
    cov_write_then_read: cover property (WR_EN_I ##1 RD_EN_I ##1 RD_VALID_O);
endmodule

// ### sem_ecc_mem_tb_top.sv
/*
 * Self-checking bench: three width pairings of the soft-ECC memory, each
 * driven by its own user model, one checker and one verdict.
 * Assumes the package, lane interface, codec and memory are compiled first.
 */
`timescale 1ns/1ps
module sem_env #(
    parameter int WR_WIDTH = 32,
    parameter int RD_WIDTH = 32,
    parameter int WR_DEPTH = 4,
    localparam int G = (WR_WIDTH < RD_WIDTH) ? WR_WIDTH : RD_WIDTH,
    localparam int WAW = $clog2(WR_DEPTH),
    localparam int RAW = $clog2(WR_DEPTH * (WR_WIDTH / G) / (RD_WIDTH / G))
) (
    input wire logic clk_i,   // Bench clock
    input wire logic rst_b_i  // Shared reset, low
);
    logic wr_en, inj_s, inj_d, rd_en, rd_valid, sbit, dbit, layout;  // Strobes and flags
    logic [WAW-1:0] wr_addr;          // Write address
    logic [WR_WIDTH-1:0] wr_data;     // Write data
    logic [RAW-1:0] rd_addr, ecc_adr; // Read and answer address
    logic [RD_WIDTH-1:0] rd_data;     // Answer data

    sem_ecc_mem #(.WR_WIDTH(WR_WIDTH), .RD_WIDTH(RD_WIDTH), .WR_DEPTH(WR_DEPTH)) dut (
        .MCLK_I(clk_i), .RST_B_I(rst_b_i), .WR_EN_I(wr_en), .WR_ADDR_I(wr_addr),
        .WR_DATA_I(wr_data), .INJ_SBIT_I(inj_s), .INJ_DBIT_I(inj_d), .RD_EN_I(rd_en),
        .RD_ADDR_I(rd_addr), .RD_DATA_O(rd_data), .RD_VALID_O(rd_valid),
        .SBIT_ERR_O(sbit), .DBIT_ERR_O(dbit), .RD_ADDR_ECC_O(ecc_adr),
        .SIMPLE_TWO_PORT_LAYOUT_O(layout)
    );

    sem_user_model #(.WR_WIDTH(WR_WIDTH), .RD_WIDTH(RD_WIDTH), .WR_DEPTH(WR_DEPTH)) m (
        .clk_i(clk_i), .wr_en_o(wr_en), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
        .inj_s_o(inj_s), .inj_d_o(inj_d), .rd_en_o(rd_en), .rd_addr_o(rd_addr),
        .rd_data_i(rd_data), .rd_valid_i(rd_valid), .sbit_i(sbit), .dbit_i(dbit),
        .rd_addr_ecc_i(ecc_adr), .layout_i(layout)
    );
endmodule

module sem_ecc_mem_tb_top;
    logic mclk;           // Bench clock
    logic rst_b;          // Reset, low
    int fails = 0;        // Mismatches seen
    int checks_done = 0;  // Comparisons made

    localparam int WRW [3] = '{32, 64, 1};   // Write widths per pairing
    localparam int RDW [3] = '{32, 1, 64};   // Read widths per pairing
    localparam int DEP [3] = '{4, 2, 128};   // Write depths per pairing

    for (genvar c = 0; c < 3; c++) begin : g_env
        sem_env #(.WR_WIDTH(WRW[c]), .RD_WIDTH(RDW[c]), .WR_DEPTH(DEP[c])) e (
            .clk_i(mclk), .rst_b_i(rst_b));
    end

    // Compares one value and reports a difference
    task automatic check(input string what, input logic [71:0] seen, input logic [71:0] want);
        checks_done++;
        if (seen !== want) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, want, seen);
        end
    endtask

    // Prints counts and verdict, then stops
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Reset, then each pairing in turn
    initial begin
        rst_b = 1'b0;
        void'($urandom(23));
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        rst_b = 1'b1;
        g_env[0].e.m.run(300);
        $display("test equal widths done");
        g_env[1].e.m.run(300);
        $display("test wide write narrow read done");
        g_env[2].e.m.run(300);
        $display("test narrow write wide read done");
        final_report();
    end

    // Cuts a hang short well past the expected run of about 1050 cycles
    initial begin
        #(5000 * 10);
        fails++;
        final_report();
    end
endmodule

// ### sem_lane_codec.sv
/*
 * Combinational SECDED encoder and decoder for one lane.
 * Assumes the lane interface is driven on its user side.
 */
`timescale 1ns/1ps
module sem_lane_codec #(
    parameter int K = 8
) (
    sem_lane_if.codec lane    // Lane carrier
);
    localparam int CW = K + sem_pkg::sem_check_bits(K) + 1;

    sem_pkg::sem_cw_t enc;    // Full-size encoded word
    sem_pkg::sem_dec_s dec;   // Full-size decoder result

    // Encode write data, decode stored word
    always_comb begin
        enc = sem_pkg::sem_encode(sem_pkg::sem_data_t'(lane.wr_data), K);
        dec = sem_pkg::sem_decode(sem_pkg::sem_cw_t'(lane.rd_word), K);
        lane.wr_word = enc[CW-1:0];
        lane.rd_data = dec.data[K-1:0];
        lane.rd_sbit = dec.sbit;
        lane.rd_dbit = dec.dbit;
    end
endmodule

// ### sem_lane_if.sv
/*
 * One ECC lane between the memory top and its codec: data to encode,
 * stored codeword to decode, and the decoder's answer.
 * Assumes K is within the package's lane limit.
 */
`timescale 1ns/1ps
interface sem_lane_if #(parameter int K = 8);
    localparam int CW = K + sem_pkg::sem_check_bits(K) + 1;
    logic [K-1:0] wr_data;   // Data to encode
    logic [CW-1:0] wr_word;  // Encoded word
    logic [CW-1:0] rd_word;  // Stored word to decode
    logic [K-1:0] rd_data;   // Decoded data
    logic rd_sbit;           // Single-bit fault seen
    logic rd_dbit;           // Double-bit fault seen
    modport codec (input wr_data, input rd_word,
                   output wr_word, output rd_data, output rd_sbit, output rd_dbit);
    modport user (output wr_data, output rd_word,
                  input wr_word, input rd_data, input rd_sbit, input rd_dbit);
endinterface

// ### sem_pkg.sv
/*
 * Shared constants, types and SECDED Hamming functions for the soft-ECC
 * two-port memory. Assumes data lanes of at most MAX_DATA bits.
 */
package sem_pkg;
    // Documented default port geometry
    localparam int WR_WIDTH_DEF = 32;
    localparam int RD_WIDTH_DEF = 32;
    localparam int WR_DEPTH_DEF = 1024;
    // Widest lane and widest codeword the functions can carry
    localparam int MAX_DATA = 72;
    localparam int MAX_CW = 80;
    // Codeword bit flipped by a single-bit injection (a data position)
    localparam int INJ_SBIT_POS = 3;
    // Codeword bits flipped by a double-bit injection
    localparam int INJ_DBIT_POS_A = 3;
    localparam int INJ_DBIT_POS_B = 1;

    typedef logic [MAX_DATA-1:0] sem_data_t;
    typedef logic [MAX_CW-1:0] sem_cw_t;

    // Decoder result
    typedef struct packed {
        sem_data_t data;
        logic sbit;
        logic dbit;
    } sem_dec_s;

    // Number of Hamming check bits for k data bits
    function automatic int sem_check_bits(input int k);
        int p;
        p = 1;
        for (int i = 1; i < 8; i++) begin
            if ((1 << p) < k + p + 1) begin
                p = p + 1;
            end
        end
        return p;
    endfunction

    // Pulls the data bits out of a codeword, no correction
    function automatic sem_data_t sem_extract(input sem_cw_t cw, input int k);
        sem_data_t d;
        int n;
        int di;
        d = '0;
        n = k + sem_check_bits(k);
        di = 0;
        for (int pos = 1; pos < MAX_CW; pos++) begin
            if (pos <= n && (pos & (pos - 1)) != 0 && di < MAX_DATA) begin
                d[di] = cw[pos];
                di = di + 1;
            end
        end
        return d;
    endfunction

    // Encodes k data bits; bit 0 is the overall parity
    function automatic sem_cw_t sem_encode(input sem_data_t d, input int k);
        sem_cw_t cw;
        int n;
        int di;
        logic par;
        cw = '0;
        n = k + sem_check_bits(k);
        di = 0;
        for (int pos = 1; pos < MAX_CW; pos++) begin
            if (pos <= n && (pos & (pos - 1)) != 0 && di < MAX_DATA) begin
                cw[pos] = d[di];
                di = di + 1;
            end
        end
        for (int b = 0; b < 7; b++) begin
            par = 1'b0;
            for (int pos = 1; pos < MAX_CW; pos++) begin
                if (pos <= n && ((pos >> b) & 1) == 1) begin
                    par = par ^ cw[pos];
                end
            end
            if ((1 << b) <= n) begin
                cw[1 << b] = par;
            end
        end
        cw[0] = ^cw;
        return cw;
    endfunction

    // Decodes; corrects one bit, flags two without correcting
    function automatic sem_dec_s sem_decode(input sem_cw_t cw, input int k);
        sem_dec_s r;
        sem_cw_t fix;
        int n;
        int syn;
        logic all_par;
        n = k + sem_check_bits(k);
        syn = 0;
        for (int pos = 1; pos < MAX_CW; pos++) begin
            if (pos <= n && cw[pos]) begin
                syn = syn ^ pos;
            end
        end
        all_par = ^cw;
        fix = cw;
        r.sbit = all_par && syn <= n;
        r.dbit = (syn != 0 && !all_par) || (all_par && syn > n);
        if (r.sbit) begin
            fix[syn] = ~fix[syn];
        end
        r.data = r.dbit ? sem_extract(cw, k) : sem_extract(fix, k);
        return r;
    endfunction
endpackage

// ### sem_user_model.sv
/*
 * Behavioural user logic for the soft-ECC memory: drives both ports at the
 * falling edge, keeps a shadow of every lane and checks each read answer.
 * Assumes a bench top named sem_ecc_mem_tb_top that owns the check task.
 */
`timescale 1ns/1ps
module sem_user_model #(
    parameter int WR_WIDTH = 32,
    parameter int RD_WIDTH = 32,
    parameter int WR_DEPTH = 4,
    localparam int G = (WR_WIDTH < RD_WIDTH) ? WR_WIDTH : RD_WIDTH,
    localparam int WU = WR_WIDTH / G,
    localparam int RU = RD_WIDTH / G,
    localparam int WAW = $clog2(WR_DEPTH),
    localparam int RAW = $clog2(WR_DEPTH * WU / RU)
) (
    input wire logic clk_i,                     // Bench clock
    output logic wr_en_o,                       // Write request
    output logic [WAW-1:0] wr_addr_o,           // Write address
    output logic [WR_WIDTH-1:0] wr_data_o,      // Write data
    output logic inj_s_o,                       // One-bit fault request
    output logic inj_d_o,                       // Two-bit fault request
    output logic rd_en_o,                       // Read request
    output logic [RAW-1:0] rd_addr_o,           // Read address
    input wire logic [RD_WIDTH-1:0] rd_data_i,  // Answer data
    input wire logic rd_valid_i,                // Answer strobe
    input wire logic sbit_i,                    // One-bit fault flag
    input wire logic dbit_i,                    // Two-bit fault flag
    input wire logic [RAW-1:0] rd_addr_ecc_i,   // Answer address
    input wire logic layout_i                   // Equal-width organisation
);
    typedef struct {
        logic [71:0] d;  // Expected data
        logic s;         // Expected one-bit flag
        logic b;         // Expected two-bit flag
        logic [71:0] a;  // Expected answer address
        int t;           // Cycle the answer is due
    } sem_exp_s;
    logic [G-1:0] lane [WR_DEPTH*WU];  // Shadow of stored lanes
    logic [1:0] fault [WR_DEPTH*WU];   // Lane fault: 0 none, 1 one-bit, 2 two-bit
    sem_exp_s exp_q[$];                // Pending read answers
    sem_exp_s e_now;                   // Answer being compared
    int cyc;                           // Rising edges seen

    // Idle port values from time zero
    initial begin
        cyc = 0;
        wr_en_o = 1'b0;
        wr_addr_o = '0;
        wr_data_o = '0;
        inj_s_o = 1'b0;
        inj_d_o = 1'b0;
        rd_en_o = 1'b0;
        rd_addr_o = '0;
    end

    // One cycle: note the read answer from old contents, then apply the write
    task automatic step(input logic we, input logic re, input logic [WAW-1:0] wa,
                        input logic [1:0] inj);
        sem_exp_s e;
        logic [RAW-1:0] ra;
        logic [WR_WIDTH-1:0] wd;
        int i;
        @(negedge clk_i);
        ra = RAW'($urandom);
        wd = WR_WIDTH'({$urandom, $urandom});
        // Answer shows at the rising edge that takes the request, one edge after it is driven
        e = '{d: '0, s: 1'b0, b: 1'b0, a: 72'(ra), t: cyc + 1};
        // two-bit lanes come back raw, first data bit flipped
        for (int v = 0; v < RU; v++) begin
            i = int'(ra) * RU + v;
            e.d[v*G +: G] = (fault[i] == 2'd2) ? lane[i] ^ G'(1) : lane[i];
            e.b = e.b | (fault[i] == 2'd2);
            e.s = e.s | (fault[i] == 2'd1);
        end
        // two-bit fault hides the one-bit flag
        e.s = e.s & ~e.b;
        if (re) begin
            exp_q.push_back(e);
        end
        // injection lands in lane 0, two-bit wins
        if (we) begin
            for (int u = 0; u < WU; u++) begin
                i = int'(wa) * WU + u;
                lane[i] = wd[u*G +: G];
                fault[i] = (u != 0) ? 2'd0 : (inj[1] ? 2'd2 : {1'b0, inj[0]});
            end
        end
        wr_en_o = we;
        wr_addr_o = wa;
        wr_data_o = wd;
        inj_d_o = inj[1];
        inj_s_o = inj[0];
        rd_en_o = re;
        rd_addr_o = ra;
    endtask

    // Fills every write address clean, then mixes random traffic
    task automatic run(input int n);
        for (int a = 0; a < WR_DEPTH; a++) begin
            step(1'b1, 1'b0, WAW'(a), 2'b00);
        end
        for (int k = 0; k < n; k++) begin
            step(1'($urandom), 1'($urandom), WAW'($urandom), 2'($urandom));
        end
        repeat (3) step(1'b0, 1'b0, '0, 2'b00);
        sem_ecc_mem_tb_top.check("layout", 72'(layout_i), 72'(WR_WIDTH == RD_WIDTH));
        sem_ecc_mem_tb_top.check("pending", 72'(exp_q.size()), 72'd0);
    endtask

    // Counts rising edges for answer timing
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
    end

    // Takes the oldest note whenever an answer strobe shows
    always @(negedge clk_i) begin
        if (rd_valid_i !== 1'b0) begin
            if (exp_q.size() == 0) begin
                sem_ecc_mem_tb_top.check("stray", 72'(rd_valid_i), 72'd0);
            end else begin
                e_now = exp_q.pop_front();
                sem_ecc_mem_tb_top.check("cycle", 72'(cyc), 72'(e_now.t));
                sem_ecc_mem_tb_top.check("data", 72'(rd_data_i), e_now.d);
                sem_ecc_mem_tb_top.check("sbit", 72'(sbit_i), 72'(e_now.s));
                sem_ecc_mem_tb_top.check("dbit", 72'(dbit_i), 72'(e_now.b));
                sem_ecc_mem_tb_top.check("addr", 72'(rd_addr_ecc_i), e_now.a);
            end
        end
    end
endmodule
